// >>> core/dpb_chain_table.sv
// Fixed property table of the 25 selectable processing chains
`timescale 1ns/10ps
module dpb_chain_table
    import dpb_pkg::*;
(
    input  wire logic [4:0] chain_sel,
    output dpb_filter_t     filter_type,
    output logic            stereo,
    output logic            iir_on,
    output logic [2:0]      n_biquads,
    output logic            drc_on,
    output logic            fx3d_on,
    output logic            beep_on
);
    logic [9:0] row;

    always_comb begin
        case (chain_sel)
            5'h01:   row = {DPB_FILT_A, 1'b1, 1'b0, 3'h3, 3'h0}; // R9
            5'h02:   row = {DPB_FILT_A, 1'b1, 1'b1, 3'h6, 3'h4};
            5'h03:   row = {DPB_FILT_A, 1'b1, 1'b1, 3'h6, 3'h0};
            5'h04:   row = {DPB_FILT_A, 1'b0, 1'b0, 3'h3, 3'h0}; // R10
            5'h05:   row = {DPB_FILT_A, 1'b0, 1'b1, 3'h6, 3'h4};
            5'h06:   row = {DPB_FILT_A, 1'b0, 1'b1, 3'h6, 3'h0};
            5'h07:   row = {DPB_FILT_B, 1'b1, 1'b1, 3'h0, 3'h0}; // R11
            5'h08:   row = {DPB_FILT_B, 1'b1, 1'b0, 3'h4, 3'h4};
            5'h09:   row = {DPB_FILT_B, 1'b1, 1'b0, 3'h4, 3'h0};
            5'h0A:   row = {DPB_FILT_B, 1'b1, 1'b1, 3'h6, 3'h4};
            5'h0B:   row = {DPB_FILT_B, 1'b1, 1'b1, 3'h6, 3'h0};
            5'h0C:   row = {DPB_FILT_B, 1'b0, 1'b1, 3'h0, 3'h0};
            5'h0D:   row = {DPB_FILT_B, 1'b0, 1'b0, 3'h4, 3'h4};
            5'h0E:   row = {DPB_FILT_B, 1'b0, 1'b0, 3'h4, 3'h0};
            5'h0F:   row = {DPB_FILT_B, 1'b0, 1'b1, 3'h6, 3'h4};
            5'h10:   row = {DPB_FILT_B, 1'b0, 1'b1, 3'h6, 3'h0};
            5'h11:   row = {DPB_FILT_C, 1'b1, 1'b1, 3'h0, 3'h0}; // R12
            5'h12:   row = {DPB_FILT_C, 1'b1, 1'b1, 3'h4, 3'h4};
            5'h13:   row = {DPB_FILT_C, 1'b1, 1'b1, 3'h4, 3'h0};
            5'h14:   row = {DPB_FILT_C, 1'b0, 1'b1, 3'h0, 3'h0};
            5'h15:   row = {DPB_FILT_C, 1'b0, 1'b1, 3'h4, 3'h4};
            5'h16:   row = {DPB_FILT_C, 1'b0, 1'b1, 3'h4, 3'h0};
            5'h17:   row = {DPB_FILT_A, 1'b1, 1'b0, 3'h2, 3'h2}; // R13
            5'h18:   row = {DPB_FILT_A, 1'b1, 1'b1, 3'h5, 3'h6};
            5'h19:   row = {DPB_FILT_A, 1'b1, 1'b1, 3'h5, 3'h7};
            default: row = {DPB_FILT_A, 1'b1, 1'b0, 3'h3, 3'h0};
        endcase
    end

    assign filter_type = dpb_filter_t'(row[9:8]); // R4
    assign stereo      = row[7];
    assign iir_on      = row[6];
    assign n_biquads   = row[5:3];
    assign drc_on      = row[2];
    assign fx3d_on     = row[1];
    assign beep_on     = row[0];
endmodule

// >>> core/dpb_core.sv
// Playback processing engine with chain select, coefficients and control registers
// What this block does
// R1: Accept any sample rate 8 to 192 kHz.
// R2: Processing engine precedes interpolation and modulator.
// R3: Oversampling ratio 1..1024 over two registers.
// R4: Three interpolation filter types, chosen by chain.
// R5: Channel power bits D7 left, D6 right.
// R6: Left clipping flag read-only bit D7.
// R7: Right clipping flag bit D6, writes ignored.
// R8: Exactly 25 fixed selectable processing chains.
// R9: Filter A stereo chains one to three.
// R10: Left-only chains 4-6, 12-16, 20-22.
// R11: Filter B stereo chains seven to eleven.
// R12: Filter C chains all use IIR.
// R13: Chains 23-25 add 3D, compression, beep.
// R14: IIR and biquads use programmable coefficients.
// R15: Coefficients 16-bit 1.15 in two registers.
// R16: Coefficients locked while running unless adaptive.
// R17: Absent sections pass samples unchanged.
// R18: Left-only chains keep right path idle.
`timescale 1ns/10ps
module dpb_core
    import dpb_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_page,
    input  wire logic [6:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire logic [SAMPLE_W-1:0] in_left,
    input  wire logic [SAMPLE_W-1:0] in_right,
    output logic                     out_valid,
    output logic      [SAMPLE_W-1:0] out_left,
    output logic      [SAMPLE_W-1:0] out_right,
    output logic      [1:0]          interp_filter,
    output logic      [10:0]         osr_ratio,
    output logic                     left_active,
    output logic                     right_active,
    output logic                     drc_enable,
    output logic                     effect_3d_enable,
    output logic                     beep_enable,
    output logic                     coef_buffer
);
    typedef struct packed {
        dpb_state_t          st;
        logic                ch;
        logic [2:0]          sec;
        logic [SAMPLE_W-1:0] work_l;
        logic [SAMPLE_W-1:0] work_r;
        logic [SAMPLE_W-1:0] out_l;
        logic [SAMPLE_W-1:0] out_r;
        logic                out_v;
        logic [1:0]          osr_hi;
        logic [7:0]          osr_lo;
        logic                pwr_l;
        logic                pwr_r;
        logic [4:0]          chain_sel;
        logic                adapt;
        logic                swap_req;
        logic                buf_sel;
        logic                clip_l;
        logic                clip_r;
        logic [7:0]          rdata;
    } dpb_core_t;

    dpb_core_t                  q;
    dpb_core_t                  next_q;
    logic        [COEF_W-1:0]   coef_mem [COEF_WORDS];
    logic signed [SAMPLE_W-1:0] hx1 [N_CH*N_SECT];
    logic signed [SAMPLE_W-1:0] hx2 [N_CH*N_SECT];
    logic signed [SAMPLE_W-1:0] hy1 [N_CH*N_SECT];
    logic signed [SAMPLE_W-1:0] hy2 [N_CH*N_SECT];

    dpb_filter_t                tab_filter;
    logic                       tab_stereo;
    logic                       tab_iir;
    logic [2:0]                 tab_nbq;
    logic                       tab_drc;
    logic                       tab_3d;
    logic                       tab_beep;

    dpb_coef_loc_t              loc;
    logic                       running;
    logic                       locked;
    logic                       take;
    logic                       right_go;
    logic                       present;
    logic                       sec_clip;
    logic                       coef_we;
    logic        [7:0]          coef_widx;
    logic        [3:0]          hidx;
    logic signed [SAMPLE_W-1:0] x_cur;
    logic signed [SAMPLE_W-1:0] y_sec;
    logic signed [SAMPLE_W-1:0] sec_out;
    logic signed [COEF_W-1:0]   cw [N_COEF];
    logic signed [43:0]         acc;

    function automatic dpb_coef_loc_t coef_decode(input logic [7:0] page, input logic [6:0] ofs);
        dpb_coef_loc_t l;
        logic [6:0]    rel;
        l   = '0;
        rel = '0;
        if (page == PAGE_COEF_A_BQ || page == PAGE_COEF_B_BQ) begin
            l.bufsel = (page == PAGE_COEF_B_BQ);
            if (ofs >= OFS_BQ_LEFT && ofs < OFS_BQ_LEFT + BQ_SPAN) begin
                rel     = ofs - OFS_BQ_LEFT;
                l.valid = 1'b1;
            end else if (ofs >= OFS_BQ_RIGHT && ofs < OFS_BQ_RIGHT + BQ_SPAN) begin
                rel     = ofs - OFS_BQ_RIGHT;
                l.valid = 1'b1;
                l.ch    = 1'b1;
            end
            l.sec = 3'(rel / BQ_REGS + 7'h01);
            l.k   = 3'((rel % BQ_REGS) >> 1);
            l.hi  = ~rel[0];
        end else if (page == PAGE_COEF_A_IIR || page == PAGE_COEF_B_IIR) begin
            l.bufsel = (page == PAGE_COEF_B_IIR);
            if (ofs >= OFS_IIR_LEFT && ofs < OFS_IIR_LEFT + IIR_REGS + IIR_REGS) begin
                rel     = ofs - OFS_IIR_LEFT;
                l.valid = 1'b1;
                l.ch    = (rel >= IIR_REGS);
                if (l.ch) begin
                    rel = rel - IIR_REGS;
                end
            end
            // IIR denominator shares the biquad D1 slot
            l.k  = (rel[2:1] == 2'h2) ? 3'h3 : {1'b0, rel[2:1]};
            l.hi = ~rel[0];
        end
        return l;
    endfunction

    function automatic logic [7:0] coef_index(input logic b, input logic c, input logic [2:0] s,
                                              input logic [2:0] k);
        return 8'(((int'(b) * N_CH + int'(c)) * N_SECT + int'(s)) * N_COEF + int'(k));
    endfunction

    function automatic logic signed [43:0] mac_term(input logic signed [COEF_W-1:0] c,
                                                    input logic signed [SAMPLE_W-1:0] v,
                                                    input logic dbl);
        logic signed [39:0] p;
        p = c * v;
        return dbl ? (44'(p) <<< 1) : 44'(p);
    endfunction

    dpb_chain_table u_table (
        .chain_sel   (q.chain_sel),
        .filter_type (tab_filter),
        .stereo      (tab_stereo),
        .iir_on      (tab_iir),
        .n_biquads   (tab_nbq),
        .drc_on      (tab_drc),
        .fx3d_on     (tab_3d),
        .beep_on     (tab_beep)
    );

    assign running  = q.pwr_l | q.pwr_r;
    assign locked   = running & ~q.adapt; // R16
    assign loc      = coef_decode(reg_page, reg_addr);
    assign take     = in_valid & in_ready; // R1
    assign right_go = tab_stereo & q.pwr_r; // R18
    assign hidx     = 4'(int'(q.ch) * N_SECT + int'(q.sec));
    assign x_cur    = q.ch ? q.work_r : q.work_l;
    assign present  = (q.sec == 3'h0) ? tab_iir : (q.sec <= tab_nbq); // R17

    always_comb begin
        for (int k = 0; k < N_COEF; k++) begin
            cw[k] = coef_mem[coef_index(q.buf_sel, q.ch, q.sec, 3'(k))]; // R14
        end
        acc = mac_term(cw[0], x_cur, 1'b0) + mac_term(cw[1], hx1[hidx], q.sec != 3'h0)
            + mac_term(cw[2], hx2[hidx], 1'b0) + mac_term(cw[3], hy1[hidx], q.sec != 3'h0)
            + mac_term(cw[4], hy2[hidx], 1'b0);
        acc      = acc >>> FRAC_BITS;
        // Saturate instead of wrapping; wrap would flip the sign audibly
        sec_clip = present & (acc[43:23] != {21{acc[23]}});
        y_sec    = (acc[43:23] != {21{acc[23]}}) ? (acc[43] ? 24'h800000 : 24'h7FFFFF) : acc[23:0];
        sec_out  = present ? y_sec : x_cur; // R17
    end

    assign coef_we   = reg_wr & loc.valid & ~locked; // R16
    assign coef_widx = coef_index((running & q.adapt) ? ~q.buf_sel : loc.bufsel, loc.ch, loc.sec, loc.k);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < COEF_WORDS; i++) begin
                coef_mem[i] <= (i % N_COEF == 0) ? COEF_UNITY : 16'h0000;
            end
        end else if (coef_we) begin
            if (loc.hi) begin
                coef_mem[coef_widx][15:8] <= reg_wdata; // R15
            end else begin
                coef_mem[coef_widx][7:0] <= reg_wdata; // R15
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < N_CH * N_SECT; i++) begin
                hx1[i] <= 24'h000000;
                hx2[i] <= 24'h000000;
                hy1[i] <= 24'h000000;
                hy2[i] <= 24'h000000;
            end
        end else if (q.st == DPB_CALC && present) begin
            hx1[hidx] <= x_cur;
            hx2[hidx] <= hx1[hidx];
            hy1[hidx] <= y_sec;
            hy2[hidx] <= hy1[hidx];
        end
    end

    always_comb begin
        next_q       = q;
        next_q.out_v = 1'b0;
        case (q.st)
            DPB_IDLE: begin
                if (take) begin
                    next_q.work_l = in_left;
                    next_q.work_r = in_right;
                    next_q.sec    = 3'h0;
                    next_q.ch     = ~q.pwr_l;
                    next_q.st     = (q.pwr_l | right_go) ? DPB_CALC : DPB_OUT;
                    // Buffer swap lands only on a sample boundary
                    if (q.swap_req) begin
                        next_q.buf_sel  = ~q.buf_sel;
                        next_q.swap_req = 1'b0;
                    end
                end
            end
            DPB_CALC: begin
                if (q.ch) begin
                    next_q.work_r = sec_out;
                    next_q.clip_r = q.clip_r | sec_clip; // R7
                end else begin
                    next_q.work_l = sec_out;
                    next_q.clip_l = q.clip_l | sec_clip; // R6
                end
                if (q.sec == 3'(N_SECT - 1)) begin
                    next_q.sec = 3'h0;
                    if (!q.ch && right_go) begin
                        next_q.ch = 1'b1;
                    end else begin
                        next_q.st = DPB_OUT;
                    end
                end else begin
                    next_q.sec = q.sec + 3'h1;
                end
            end
            DPB_OUT: begin
                next_q.out_l = q.pwr_l ? q.work_l : 24'h000000; // R5
                next_q.out_r = right_go ? q.work_r : 24'h000000; // R18
                next_q.out_v = 1'b1; // R2
                next_q.st    = DPB_IDLE;
            end
            default: begin
                next_q.st = DPB_IDLE;
            end
        endcase

        if (reg_rd) begin
            next_q.rdata = 8'h00;
            if (loc.valid) begin
                next_q.rdata = locked ? 8'h00 : (loc.hi ? coef_mem[coef_index(loc.bufsel, loc.ch, loc.sec,
                               loc.k)][15:8] : coef_mem[coef_index(loc.bufsel, loc.ch, loc.sec, loc.k)][7:0]);
            end else if (reg_page == PAGE_CTRL) begin
                case (reg_addr)
                    OFS_OSR_HIGH:   next_q.rdata = {6'h00, q.osr_hi};
                    OFS_OSR_LOW:    next_q.rdata = q.osr_lo;
                    OFS_CLIP_FLAGS: next_q.rdata = {q.clip_l, q.clip_r, 6'h00};
                    OFS_CHAIN_SEL:  next_q.rdata = {3'h0, q.chain_sel};
                    OFS_CH_POWER:   next_q.rdata = {q.pwr_l, q.pwr_r, 6'h00};
                    default:        next_q.rdata = 8'h00;
                endcase
            end else if (reg_page == PAGE_COEF_A_BQ && reg_addr == OFS_ADAPT_CTRL) begin
                next_q.rdata = {5'h00, q.adapt, q.buf_sel, q.swap_req};
            end
            // Clear on read; a clip in this same cycle survives
            if (reg_page == PAGE_CTRL && reg_addr == OFS_CLIP_FLAGS) begin
                next_q.clip_l = (q.st == DPB_CALC && !q.ch) ? sec_clip : 1'b0;
                next_q.clip_r = (q.st == DPB_CALC && q.ch) ? sec_clip : 1'b0;
            end
        end

        if (reg_wr && reg_page == PAGE_CTRL) begin
            case (reg_addr)
                OFS_OSR_HIGH: next_q.osr_hi = reg_wdata[1:0]; // R3
                OFS_OSR_LOW:  next_q.osr_lo = reg_wdata; // R3
                OFS_CH_POWER: begin
                    next_q.pwr_l = reg_wdata[BIT_LEFT]; // R5
                    next_q.pwr_r = reg_wdata[BIT_RIGHT]; // R5
                end
                OFS_CHAIN_SEL: begin
                    // Out-of-range chain numbers are ignored
                    if (reg_wdata >= 8'h01 && reg_wdata <= 8'(N_CHAINS)) begin
                        next_q.chain_sel = reg_wdata[4:0]; // R8
                    end
                end
                default: next_q.st = next_q.st; // R7
            endcase
        end
        if (reg_wr && reg_page == PAGE_COEF_A_BQ && reg_addr == OFS_ADAPT_CTRL) begin
            next_q.adapt = reg_wdata[BIT_ADAPT_EN];
            if (reg_wdata[BIT_SWAP] && reg_wdata[BIT_ADAPT_EN] && running) begin
                next_q.swap_req = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            q           <= '0;
            q.osr_hi    <= RST_OSR_HIGH;
            q.osr_lo    <= RST_OSR_LOW;
            q.chain_sel <= RST_CHAIN;
        end else begin
            q <= next_q;
        end
    end

    assign in_ready         = (q.st == DPB_IDLE);
    assign reg_rdata        = q.rdata;
    assign out_valid        = q.out_v;
    assign out_left         = q.out_l;
    assign out_right        = q.out_r;
    assign interp_filter    = tab_filter; // R4
    assign osr_ratio        = ({q.osr_hi, q.osr_lo} == 10'h000) ? OSR_MAX : {1'b0, q.osr_hi, q.osr_lo}; // R3
    assign left_active      = q.pwr_l;
    assign right_active     = right_go;
    assign drc_enable       = tab_drc; // R13
    assign effect_3d_enable = tab_3d; // R13
    assign beep_enable      = tab_beep; // R13
    assign coef_buffer      = q.buf_sel;

    a_out_latency: assert property (@(posedge ref_clk) disable iff (reset) // R2
        take |-> ##[2:16] out_valid)
        else $error("sample not delivered in time");
    a_right_idle: assert property (@(posedge ref_clk) disable iff (reset) // R18
        out_valid && !$past(right_go) |-> out_right == 24'h000000)
        else $error("right output active in left-only chain");
    a_left_power: assert property (@(posedge ref_clk) disable iff (reset) // R5
        out_valid && !$past(q.pwr_l) |-> out_left == 24'h000000)
        else $error("left output while powered down");
    a_clip_sets: assert property (@(posedge ref_clk) disable iff (reset) // R6
        q.st == DPB_CALC && !q.ch && sec_clip |=> q.clip_l)
        else $error("left clip not flagged");
    a_lock_read: assert property (@(posedge ref_clk) disable iff (reset) // R16
        reg_rd && loc.valid && locked |=> reg_rdata == 8'h00)
        else $error("locked coefficient readable");
    a_osr_range: assert property (@(posedge ref_clk) disable iff (reset) // R3
        osr_ratio >= 11'h001 && osr_ratio <= OSR_MAX)
        else $error("oversampling ratio out of range");
    a_filter_legal: assert property (@(posedge ref_clk) disable iff (reset) // R4
        interp_filter != 2'h3)
        else $error("illegal interpolation filter");
    a_chain_range: assert property (@(posedge ref_clk) disable iff (reset) // R8
        q.chain_sel >= 5'h01 && q.chain_sel <= 5'h19)
        else $error("chain number out of range");
    a_chain_two: assert property (@(posedge ref_clk) disable iff (reset) // R9
        q.chain_sel == 5'h02 |-> tab_iir && tab_nbq == 3'h6 && tab_drc && tab_stereo)
        else $error("chain 2 properties wrong");
    a_filter_c_iir: assert property (@(posedge ref_clk) disable iff (reset) // R12
        tab_filter == DPB_FILT_C |-> tab_iir)
        else $error("filter C chain without IIR");
    a_bypass: assert property (@(posedge ref_clk) disable iff (reset) // R17
        q.st == DPB_CALC && !present && !q.ch |=> q.work_l == $past(q.work_l))
        else $error("absent section altered sample");
    a_swap_take: assert property (@(posedge ref_clk) disable iff (reset) // R14
        take && q.swap_req |=> q.buf_sel != $past(q.buf_sel))
        else $error("buffer swap missed");
endmodule

// >>> core/dpb_pkg.sv
// Shared constants and types for the playback processing chain selector
package dpb_pkg;

    localparam int SAMPLE_W   = 24;
    localparam int COEF_W     = 16;
    localparam int FRAC_BITS  = 15;
    localparam int N_SECT     = 7;
    localparam int N_COEF     = 5;
    localparam int N_CH       = 2;
    localparam int N_BUF      = 2;
    localparam int COEF_WORDS = N_BUF * N_CH * N_SECT * N_COEF;
    localparam int N_CHAINS   = 25;

    localparam logic [7:0] PAGE_CTRL       = 8'h00;
    localparam logic [7:0] PAGE_COEF_A_BQ  = 8'h08;
    localparam logic [7:0] PAGE_COEF_A_IIR = 8'h09;
    localparam logic [7:0] PAGE_COEF_B_BQ  = 8'h0C;
    localparam logic [7:0] PAGE_COEF_B_IIR = 8'h0D;

    localparam logic [6:0] OFS_OSR_HIGH   = 7'h0D;
    localparam logic [6:0] OFS_OSR_LOW    = 7'h0E;
    localparam logic [6:0] OFS_CLIP_FLAGS = 7'h27;
    localparam logic [6:0] OFS_CHAIN_SEL  = 7'h3C;
    localparam logic [6:0] OFS_CH_POWER   = 7'h3F;
    localparam logic [6:0] OFS_ADAPT_CTRL = 7'h01;
    localparam logic [6:0] OFS_BQ_LEFT    = 7'h02;
    localparam logic [6:0] OFS_BQ_RIGHT   = 7'h42;
    localparam logic [6:0] BQ_REGS        = 7'h0A;
    localparam logic [6:0] BQ_SPAN        = 7'h3C;
    localparam logic [6:0] OFS_IIR_LEFT   = 7'h02;
    localparam logic [6:0] IIR_REGS       = 7'h06;

    localparam int BIT_LEFT     = 7;
    localparam int BIT_RIGHT    = 6;
    localparam int BIT_ADAPT_EN = 2;
    localparam int BIT_BUF_USE  = 1;
    localparam int BIT_SWAP     = 0;

    localparam logic [1:0]  RST_OSR_HIGH = 2'h0;
    localparam logic [7:0]  RST_OSR_LOW  = 8'h80;
    localparam logic [4:0]  RST_CHAIN    = 5'h01;
    localparam logic [15:0] COEF_UNITY   = 16'h7FFF;
    localparam logic [10:0] OSR_MAX      = 11'h400;

    typedef enum logic [1:0] {
        DPB_IDLE = 2'b00,
        DPB_CALC = 2'b01,
        DPB_OUT  = 2'b11
    } dpb_state_t;

    typedef enum logic [1:0] {
        DPB_FILT_A = 2'b00,
        DPB_FILT_B = 2'b01,
        DPB_FILT_C = 2'b10
    } dpb_filter_t;

    typedef struct packed {
        logic       valid;
        logic       bufsel;
        logic       ch;
        logic [2:0] sec;
        logic [2:0] k;
        logic       hi;
    } dpb_coef_loc_t;

endpackage

// >>> test/dpb_src_model.sv
// Sample source model feeding the playback stream
`timescale 1ns/10ps
module dpb_src_model
    import dpb_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                go,
    input  wire logic [SAMPLE_W-1:0] x,
    input  wire logic                in_ready,
    output logic                     in_valid,
    output logic      [SAMPLE_W-1:0] in_left,
    output logic      [SAMPLE_W-1:0] in_right
);
    // Offer held until taken; released lines invert so stale data never matches
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            in_valid <= 1'b0;
            in_left  <= '0;
            in_right <= '0;
        end else if (go) begin
            in_valid <= 1'b1;
            in_left  <= x;
            in_right <= x;
        end else if (in_valid && in_ready) begin
            in_valid <= 1'b0;
            in_left  <= ~in_left;
            in_right <= ~in_right;
        end
    end
endmodule

// >>> test/test_dac_processing_block_select.sv
// Self-checking bench for the playback chain selector
`timescale 1ns/10ps
module test_dac_processing_block_select;
    import dpb_pkg::*;
    logic                ref_clk, reset, reg_wr, reg_rd, go, in_valid, in_ready, out_valid;
    logic                left_active, right_active, drc_enable, effect_3d_enable, beep_enable, coef_buffer;
    logic [7:0]          reg_page, reg_wdata, reg_rdata, d;
    logic [6:0]          reg_addr;
    logic [SAMPLE_W-1:0] x, in_left, in_right, out_left, out_right;
    logic [1:0]          interp_filter;
    logic [10:0]         osr_ratio;
    int                  bad_count, cmp_count;

    dpb_core u_dpb_core (.ref_clk, .reset, .reg_wr, .reg_rd, .reg_page, .reg_addr, .reg_wdata, .reg_rdata,
        .in_valid, .in_ready, .in_left, .in_right, .out_valid, .out_left, .out_right, .interp_filter,
        .osr_ratio, .left_active, .right_active, .drc_enable, .effect_3d_enable, .beep_enable, .coef_buffer);
    dpb_src_model u_dpb_src_model (.ref_clk, .reset, .go, .x, .in_ready, .in_valid, .in_left, .in_right);

    task automatic stop_test;
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    // One sample pair through the engine, latency counted from the edge that raises in_valid
    task automatic smp(input logic [23:0] v, input int lat, input logic [23:0] el, input logic [23:0] er);
        int n;
        @(posedge ref_clk);
        go <= 1'b1;
        x <= v;
        @(posedge ref_clk);
        go <= 1'b0;
        @(negedge ref_clk);
        chk("offer", 24'h1, {23'h0, in_valid & in_ready});
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (out_valid !== 1'b1 && n < 40);
        if (out_valid !== 1'b1) begin
            bad_count++;
            stop_test;
        end
        chk("latency", 24'(lat), 24'(n));
        chk("out_left", el, out_left);
        chk("out_right", er, out_right);
    endtask
    task automatic t_regs;
        chk("osr reset", 24'h80, {13'h0, osr_ratio});
        rd(OFS_OSR_LOW);
        chk("osr low", 24'h80, {16'h0, d});
        wr(OFS_OSR_HIGH, 8'h03);
        wr(OFS_OSR_LOW, 8'hFF);
        @(negedge ref_clk);
        chk("osr 1023", 24'h3FF, {13'h0, osr_ratio});
        wr(OFS_OSR_HIGH, 8'h00);
        wr(OFS_OSR_LOW, 8'h00);
        @(negedge ref_clk);
        chk("osr 1024", 24'h400, {13'h0, osr_ratio});
        wr(OFS_CLIP_FLAGS, 8'hFF);
        rd(OFS_CLIP_FLAGS);
        chk("clip flags", 24'h0, {16'h0, d});
        rd(7'h7F);
        chk("unmapped", 24'h0, {16'h0, d});
        $display("test regs done");
    endtask
    // Power both channels, then walk every chain: {filter, right, drc, 3d, beep}
    task automatic t_chains;
        logic [1:0] f;
        wr(OFS_CH_POWER, 8'hC0);
        rd(OFS_CH_POWER);
        chk("power", 24'hC0, {16'h0, d});
        chk("left active", 24'h1, {23'h0, left_active});
        for (int c = 1; c <= 25; c++) begin
            wr(OFS_CHAIN_SEL, 8'(c));
            @(negedge ref_clk);
            f = (c >= 7 && c <= 16) ? 2'h1 : (c >= 17 && c <= 22) ? 2'h2 : 2'h0;
            chk("chain props", {18'h0, f, 1'(~25'h038F838 >> (c - 1)), 1'(25'h1925292 >> (c - 1)),
                1'(25'h1C00000 >> (c - 1)), 1'(25'h1000000 >> (c - 1))},
                {18'h0, interp_filter, right_active, drc_enable, effect_3d_enable, beep_enable});
        end
        wr(OFS_CHAIN_SEL, 8'h00);
        @(negedge ref_clk);
        chk("chain 0 ignored", 24'h1, {23'h0, beep_enable});
        $display("test chains done");
    endtask
    task automatic t_stream;
        wr(OFS_CHAIN_SEL, 8'h04);
        smp(24'h008000, 9, 24'h007FFD, 24'h000000);
        wr(OFS_CHAIN_SEL, 8'h07);
        smp(24'h008000, 16, 24'h007FFF, 24'h007FFF);
        smp(24'hFF8000, 16, 24'hFF8001, 24'hFF8001);
        wr(OFS_CH_POWER, 8'h80);
        smp(24'h008000, 9, 24'h007FFF, 24'h000000);
        wr(OFS_CH_POWER, 8'h40);
        smp(24'h008000, 9, 24'h000000, 24'h007FFF);
        wr(OFS_CH_POWER, 8'h00);
        smp(24'h008000, 2, 24'h000000, 24'h000000);
        $display("test stream done");
    endtask
    // Unity N1 on a full-scale step overflows 24 bits
    task automatic t_coef;
        reg_page <= PAGE_COEF_A_IIR;
        wr(7'h04, 8'h7F);
        wr(7'h05, 8'hFF);
        rd(7'h04);
        chk("coef idle", 24'h7F, {16'h0, d});
        @(posedge ref_clk) reg_page <= PAGE_CTRL;
        wr(OFS_CH_POWER, 8'h80);
        reg_page <= PAGE_COEF_A_IIR;
        rd(7'h04);
        chk("coef locked", 24'h0, {16'h0, d});
        @(posedge ref_clk) reg_page <= PAGE_CTRL;
        smp(24'h7FFFFF, 9, 24'h7FFFFF, 24'h000000);
        rd(OFS_CLIP_FLAGS);
        chk("clip set", 24'h80, {16'h0, d});
        rd(OFS_CLIP_FLAGS);
        chk("clip cleared", 24'h0, {16'h0, d});
        @(posedge ref_clk) reg_page <= PAGE_COEF_A_BQ;
        wr(OFS_ADAPT_CTRL, 8'h05);
        reg_page <= PAGE_CTRL;
        smp(24'h000000, 9, 24'h000000, 24'h000000);
        chk("buffer swap", 24'h1, {23'h0, coef_buffer});
        $display("test coef done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        {reset, reg_wr, reg_rd, go, reg_page, reg_addr, reg_wdata, x} = '0;
        reset = 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs;
        t_chains;
        t_stream;
        t_coef;
        stop_test;
    end
endmodule
